// ### dv/rpmc_partner.sv
`timescale 1ns/1ps
module rpmc_partner (
    // clock
    input wire logic clk,
    // detector and pin levels
    output logic powerOnDetect,
    output logic supplyBelowTrip,
    output logic resetOrInputPin
);
    initial begin
        powerOnDetect = 1'b0;
        supplyBelowTrip = 1'b0;
        resetOrInputPin = 1'b1;
    end
    // levels move just after an edge; a released pin is pulled high
    task drive(input logic por, input logic low, input logic pinLow);
        @(posedge clk);
        powerOnDetect <= por;
        supplyBelowTrip <= low;
        resetOrInputPin <= por | ~pinLow;
    endtask
endmodule

// ### dv/rpmc_top_assertions.sv
`timescale 1ns/1ps
module rpmc_top_assertions
    import rpmc_pkg::*;
#(
    parameter int NFLAGS = 6,
    parameter int HOLD_CYC = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // inputs
    input wire logic powerOnDetect,
    input wire logic supplyBelowTrip,
    input wire logic brownoutEnable,
    input wire logic brownoutIrqMode,
    input wire logic watchdogReset,
    input wire logic softwareReset,
    input wire logic uartBreak,
    input wire logic interruptPending,
    input wire logic wakeupInterrupt,
    input wire logic flagWrite,
    input wire logic [NFLAGS-1:0] flagWriteData,
    // outputs
    input wire logic coreReset,
    input wire logic [NFLAGS-1:0] resetSourceFlags,
    input wire logic [15:0] fetchAddress,
    input wire logic brownoutIrqReq,
    input wire logic [1:0] powerMode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic quiet;
    // pin flag left out of the clear check: its sync delay races the write
    assign quiet = !(powerOnDetect | supplyBelowTrip | watchdogReset | softwareReset | uartBreak);
    property p_wdt; watchdogReset |=> coreReset; endproperty
    a_wdt: assert property (p_wdt) else $error("no reset after watchdog");
    property p_flag; watchdogReset && !powerOnDetect |=> resetSourceFlags[2]; endproperty
    a_flag: assert property (p_flag) else $error("watchdog flag not set");
    property p_por; powerOnDetect && !flagWrite |=> resetSourceFlags == 6'h22; endproperty
    a_por: assert property (p_por) else $error("power-on flags wrong");
    property p_clr;
        flagWrite && quiet && !coreReset |=>
            (resetSourceFlags >> 1) == (($past(resetSourceFlags) & $past(flagWriteData)) >> 1);
    endproperty
    a_clr: assert property (p_clr) else $error("flag clear wrong");
    property p_boirq;
        brownoutEnable && brownoutIrqMode && supplyBelowTrip && !coreReset && powerMode != 2'h3
            |=> brownoutIrqReq;
    endproperty
    a_boirq: assert property (p_boirq) else $error("brownout irq missing");
    property p_bodis; !brownoutEnable |=> !brownoutIrqReq; endproperty
    a_bodis: assert property (p_bodis) else $error("irq while disabled");
    property p_vec; $fell(coreReset) |-> fetchAddress[7:0] == 8'h00; endproperty
    a_vec: assert property (p_vec) else $error("fetch low byte not zero");
    property p_idle; powerMode == 2'h1 && interruptPending |=> powerMode == 2'h0; endproperty
    a_idle: assert property (p_idle) else $error("idle not left");
    property p_wake; powerMode[1] && wakeupInterrupt |=> powerMode == 2'h0; endproperty
    a_wake: assert property (p_wake) else $error("power-down not left");
endmodule
bind rpmc_top rpmc_top_assertions #(.NFLAGS(NFLAGS), .HOLD_CYC(HOLD_CYC)) i_chk (
    .clk(clk), .rstn(rstn), .powerOnDetect(powerOnDetect), .supplyBelowTrip(supplyBelowTrip),
    .brownoutEnable(brownoutEnable), .brownoutIrqMode(brownoutIrqMode),
    .watchdogReset(watchdogReset), .softwareReset(softwareReset), .uartBreak(uartBreak),
    .interruptPending(interruptPending), .wakeupInterrupt(wakeupInterrupt),
    .flagWrite(flagWrite), .flagWriteData(flagWriteData), .coreReset(coreReset),
    .resetSourceFlags(resetSourceFlags), .fetchAddress(fetchAddress),
    .brownoutIrqReq(brownoutIrqReq), .powerMode(powerMode)
);

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rstn = 1'b0, flagWrite = 1'b0, resetPinEnable = 1'b1;
    logic brownoutIrqMode = 1'b0, brownoutEnable = 1'b1, forcedIsp = 1'b0;
    logic comparatorPowerDown = 1'b0;
    logic [1:0] clkSel = 2'h0;
    logic [7:0] pulses = 8'h00, bootVector = 8'h00, bootStatusByte = 8'h00;
    logic [5:0] flagWriteData = 6'h00, resetSourceFlags;
    logic [15:0] fetchAddress;
    logic [1:0] powerMode;
    logic powerOnDetect, supplyBelowTrip, resetOrInputPin, coreReset, pinInputValue;
    logic brownoutIrqReq, cpuClockEnable, periphClockEnable, mainOscEnable, rcOscEnable;
    logic brownoutDetEnable, comparatorEnable, watchdogEnable, sysTimerRun;
    int n_fail = 0, comparisons = 0, expFlags = 0, seed = 32'h2950, i;
    rpmc_top i_dut (
        .clk, .rstn, .resetOrInputPin, .resetPinEnable, .brownoutIrqMode, .brownoutEnable,
        .bootVector, .bootStatusByte, .forcedIsp, .powerOnDetect, .supplyBelowTrip,
        .watchdogReset(pulses[0]), .softwareReset(pulses[1]), .uartBreak(pulses[2]),
        .enterIdle(pulses[3]), .enterPowerDown(pulses[4]), .enterTotalPowerDown(pulses[5]),
        .interruptPending(pulses[6]), .wakeupInterrupt(pulses[7]), .rcIsSysClock(clkSel[1]),
        .sysTimerEnable(clkSel[0]), .comparatorPowerDown, .flagWrite, .flagWriteData,
        .coreReset, .resetSourceFlags, .fetchAddress, .pinInputValue, .brownoutIrqReq,
        .powerMode, .cpuClockEnable, .periphClockEnable, .mainOscEnable, .rcOscEnable,
        .brownoutDetEnable, .comparatorEnable, .watchdogEnable, .sysTimerRun
    );
    rpmc_partner i_part (.clk, .powerOnDetect, .supplyBelowTrip, .resetOrInputPin);
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
    end
    // the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
    // ****
    // tasks
    // ****
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("fails %0d checks %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task waitRel;
        int n;
        n = 0;
        // let the edge that took the source pass before looking at reset
        cyc(1);
        chk(16'(coreReset), 16'h0001);
        while (coreReset !== 1'b0 && n < 40) begin
            cyc(1);
            n++;
        end
        chk(16'(n < 40), 16'h0001);
    endtask
    // one-cycle strobe: sources, mode entries, wake-ups
    task pulse(input int k);
        @(posedge clk);
        pulses <= 8'(1 << k);
        @(posedge clk);
        pulses <= 8'h00;
        cyc(2);
    endtask
    // ****
    // sequence
    // ****
    initial begin
        cyc(3);
        i_part.drive(1'b1, 1'b0, 1'b0);
        cyc(3);
        i_part.drive(1'b0, 1'b0, 1'b0);
        waitRel();
        expFlags = 6'h22;
        chk(16'(resetSourceFlags), 16'(expFlags));
        chk(fetchAddress, 16'h0000);
        @(posedge clk);
        bootVector <= 8'($random(seed)) | 8'h01;
        for (i = 0; i < 3; i++) begin
            pulse(i);
            waitRel();
            expFlags = expFlags | (4 << i);
            chk(16'(resetSourceFlags), 16'(expFlags));
            chk(fetchAddress, (i == 2) ? {bootVector, 8'h00} : 16'h0000);
        end
        @(posedge clk);
        bootStatusByte <= 8'h01;
        pulse(1);
        waitRel();
        chk(fetchAddress, {bootVector, 8'h00});
        @(posedge clk);
        bootStatusByte <= 8'h00;
        flagWrite <= 1'b1;
        flagWriteData <= 6'($random(seed));
        @(posedge clk);
        flagWrite <= 1'b0;
        expFlags = expFlags & flagWriteData;
        cyc(1);
        chk(16'(resetSourceFlags), 16'(expFlags));
        i_part.drive(1'b0, 1'b1, 1'b0);
        i_part.drive(1'b0, 1'b0, 1'b0);
        waitRel();
        expFlags = expFlags | 2;
        chk(16'(resetSourceFlags), 16'(expFlags));
        @(posedge clk);
        brownoutIrqMode <= 1'b1;
        i_part.drive(1'b0, 1'b1, 1'b0);
        cyc(3);
        chk(16'({brownoutIrqReq, coreReset}), 16'h0002);
        i_part.drive(1'b0, 1'b0, 1'b0);
        cyc(3);
        chk(16'(brownoutIrqReq), 16'h0000);
        @(posedge clk);
        brownoutEnable <= 1'b0;
        i_part.drive(1'b0, 1'b1, 1'b0);
        cyc(3);
        chk(16'(brownoutIrqReq), 16'h0000);
        @(posedge clk);
        brownoutIrqMode <= 1'b0;
        cyc(3);
        chk(16'(coreReset), 16'h0000);
        @(posedge clk);
        resetPinEnable <= 1'b0;
        i_part.drive(1'b0, 1'b0, 1'b1);
        cyc(5);
        chk(16'({pinInputValue, coreReset}), 16'h0000);
        @(posedge clk);
        resetPinEnable <= 1'b1;
        cyc(5);
        i_part.drive(1'b0, 1'b0, 1'b0);
        waitRel();
        expFlags = expFlags | 1;
        chk(16'(resetSourceFlags), 16'(expFlags));
        chk(16'(pinInputValue), 16'h0001);
        @(posedge clk);
        forcedIsp <= 1'b1;
        brownoutEnable <= 1'b1;
        i_part.drive(1'b1, 1'b0, 1'b0);
        cyc(3);
        i_part.drive(1'b0, 1'b0, 1'b0);
        forcedIsp <= 1'b0;
        waitRel();
        chk(16'(resetSourceFlags), 16'h0022);
        chk(fetchAddress, {bootVector, 8'h00});
        pulse(3);
        chk(16'({powerMode, periphClockEnable, cpuClockEnable}), 16'h0006);
        pulse(6);
        chk(16'(powerMode), 16'h0000);
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            clkSel <= 2'(i);
            pulse(4 + i / 4);
            chk(16'({powerMode, mainOscEnable}), 16'(4 + 2 * (i / 4)));
            chk(16'(rcOscEnable), 16'(i % 4 == 3));
            chk(16'({watchdogEnable, sysTimerRun}), 16'(2 + i % 2));
            chk(16'({brownoutDetEnable, comparatorEnable}), 16'((i < 4) ? 3 : 0));
            pulse(7);
            chk(16'(powerMode), 16'h0000);
        end
        @(posedge clk);
        comparatorPowerDown <= 1'b1;
        pulse(4);
        chk(16'({comparatorEnable, brownoutDetEnable}), 16'h0001);
        pulse(7);
        chk(16'(powerMode), 16'h0000);
        end_of_test();
    end
endmodule

// ### hdl/rpmc_defines.svh
`ifndef RPMC_DEFINES_SVH
`define RPMC_DEFINES_SVH

// reset source flag positions
`define RPMC_FLAG_EXT 0
`define RPMC_FLAG_BO 1
`define RPMC_FLAG_WDT 2
`define RPMC_FLAG_SW 3
`define RPMC_FLAG_BRK 4
`define RPMC_FLAG_PO 5
`define RPMC_NFLAGS 6
// power-on reset value of the flags: power_on_flag and brownout_flag set
`define RPMC_FLAGS_POR 6'h22
`define RPMC_FLAGS_ZERO 6'h00
// fetch vectors
`define RPMC_VEC_ZERO 16'h0000
`define RPMC_VEC_LOW 8'h00
// minimum internal reset stretch
`define RPMC_RST_HOLD_NS 100
`define RPMC_CLK_MHZ 50
`define RPMC_RST_HOLD_CYC ((`RPMC_RST_HOLD_NS * `RPMC_CLK_MHZ + 999) / 1000)

`endif

// ### hdl/rpmc_pkg.sv
package rpmc_pkg;
    typedef enum logic [1:0] {
        RPMC_RUN = 2'b00,
        RPMC_IDLE = 2'b01,
        RPMC_PD = 2'b10,
        RPMC_TPD = 2'b11
    } rpmc_mode_t;
endpackage

// ### hdl/rpmc_src_gate.sv
`timescale 1ns/1ps
`include "rpmc_defines.svh"
module rpmc_src_gate
    import rpmc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // raw sources
    input wire logic resetPin,
    input wire logic resetPinEnable,
    input wire logic powerUpActive,
    input wire logic powerOnDetect,
    input wire logic supplyBelowTrip,
    input wire logic brownoutEnable,
    input wire logic brownoutIrqMode,
    input wire logic tpdActive,
    input wire logic watchdogReset,
    input wire logic softwareReset,
    input wire logic uartBreak,
    // gated requests
    rpmc_src_if.src req,
    output logic brownoutIrq
);
    logic pinMeta_r, pinMeta_nxt;
    logic pinSync_r, pinSync_nxt;
    logic boCond;

    always_comb begin
        pinMeta_nxt = resetPin;
        pinSync_nxt = pinMeta_r;
    end

    // R20: pin synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinMeta_r <= 1'b1;
            pinSync_r <= 1'b1;
        end else begin
            pinMeta_r <= pinMeta_nxt;
            pinSync_r <= pinSync_nxt;
        end
    end

    // R2 R3 R9: brownout qualified
    assign boCond = brownoutEnable && !tpdActive && supplyBelowTrip;
    // R10 R11 R12: pin reset select
    assign req.extReq = !pinSync_r && (resetPinEnable || powerUpActive);
    assign req.poReq = powerOnDetect;
    // R1: reset or interrupt
    assign req.boReq = boCond && !brownoutIrqMode;
    assign brownoutIrq = boCond && brownoutIrqMode;
    assign req.wdtReq = watchdogReset;
    assign req.swReq = softwareReset;
    assign req.brkReq = uartBreak;
endmodule

// ### hdl/rpmc_src_if.sv
`timescale 1ns/1ps
interface rpmc_src_if;
    // reset requests
    logic extReq;
    logic poReq;
    logic boReq;
    logic wdtReq;
    logic swReq;
    logic brkReq;
    modport src (output extReq, poReq, boReq, wdtReq, swReq, brkReq);
    modport snk (input extReq, poReq, boReq, wdtReq, swReq, brkReq);
endinterface

// ### hdl/rpmc_top.sv
// Function
// R1: brownout resets, or interrupts when configured
// R2: software enables brownout detection
// R3: brownout follows supply-below-trip indication
// R4: power_on_flag set at power-up, sticky
// R5: idle keeps peripherals, exits on interrupt/reset
// R6: power-down stops oscillator, wake on reset/irq
// R7: power-down keeps brownout, watchdog, comparators, timer
// R8: RC oscillator off unless clock and timer
// R9: total power-down also kills brownout, comparators
// R10: reset_pin_enable selects pin reset or input
// R11: power-up always uses pin as reset
// R12: outside must not hold pin low
// R13: six reset sources
// R14: one sticky flag per source
// R15: writing 0 clears only that flag
// R16: power-on sets power_on and brownout flags only
// R17: other resets keep flags, add new one
// R18: fetch at zero or boot vector page
// R19: boot address on break, boot_status_byte, forced ISP
// R20: sync pin, hold reset while source active
`timescale 1ns/1ps
`include "rpmc_defines.svh"
module rpmc_top
    import rpmc_pkg::*;
#(
    parameter int NFLAGS = `RPMC_NFLAGS,
    parameter int HOLD_CYC = `RPMC_RST_HOLD_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // pin and configuration
    input wire logic resetOrInputPin,
    input wire logic resetPinEnable,
    input wire logic brownoutIrqMode,
    input wire logic brownoutEnable,
    input wire logic [7:0] bootVector,
    input wire logic [7:0] bootStatusByte,
    input wire logic forcedIsp,
    // detectors and sources
    input wire logic powerOnDetect,
    input wire logic supplyBelowTrip,
    input wire logic watchdogReset,
    input wire logic softwareReset,
    input wire logic uartBreak,
    // power mode control from software
    input wire logic enterIdle,
    input wire logic enterPowerDown,
    input wire logic enterTotalPowerDown,
    input wire logic interruptPending,
    input wire logic wakeupInterrupt,
    input wire logic rcIsSysClock,
    input wire logic sysTimerEnable,
    input wire logic comparatorPowerDown,
    // flag register access
    input wire logic flagWrite,
    input wire logic [NFLAGS-1:0] flagWriteData,
    // outputs
    output logic coreReset,
    output logic [NFLAGS-1:0] resetSourceFlags,
    output logic [15:0] fetchAddress,
    output logic pinInputValue,
    output logic brownoutIrqReq,
    output logic [1:0] powerMode,
    output logic cpuClockEnable,
    output logic periphClockEnable,
    output logic mainOscEnable,
    output logic rcOscEnable,
    output logic brownoutDetEnable,
    output logic comparatorEnable,
    output logic watchdogEnable,
    output logic sysTimerRun
);
    // ******************************************
    // checks
    // ******************************************
    // flag layout is fixed; the stretch counter is only eight bits wide
    if (NFLAGS != `RPMC_NFLAGS) begin : g_badFlags
        $error("rpmc_top: NFLAGS must be 6");
    end
    if (HOLD_CYC < 1 || HOLD_CYC > 255) begin : g_badHold
        $error("rpmc_top: HOLD_CYC out of range");
    end

    // ******************************************
    // sources
    // ******************************************
    rpmc_src_if srcBus();
    logic boIrq;
    logic powerUpActive;
    logic anySrc;
    rpmc_mode_t mode_r, mode_nxt;

    assign powerUpActive = powerOnDetect;

    rpmc_src_gate uGate (
        .clk(clk),
        .rstn(rstn),
        .resetPin(resetOrInputPin),
        .resetPinEnable(resetPinEnable),
        .powerUpActive(powerUpActive),
        .powerOnDetect(powerOnDetect),
        .supplyBelowTrip(supplyBelowTrip),
        .brownoutEnable(brownoutEnable),
        .brownoutIrqMode(brownoutIrqMode),
        .tpdActive(mode_r == RPMC_TPD),
        .watchdogReset(watchdogReset),
        .softwareReset(softwareReset),
        .uartBreak(uartBreak),
        .req(srcBus.src),
        .brownoutIrq(boIrq)
    );

    // R13: any source resets
    assign anySrc = srcBus.extReq | srcBus.poReq | srcBus.boReq |
                    srcBus.wdtReq | srcBus.swReq | srcBus.brkReq;

    // ******************************************
    // reset stretch and vector
    // ******************************************
    logic [7:0] hold_r, hold_nxt;
    logic coreReset_r, coreReset_nxt;
    logic brkSeen_r, brkSeen_nxt;
    logic ispSeen_r, ispSeen_nxt;
    logic [15:0] fetch_r, fetch_nxt;
    logic bootSel;

    // R19: boot address choice
    assign bootSel = brkSeen_r || bootStatusByte[0] || ispSeen_r;

    always_comb begin
        hold_nxt = hold_r;
        coreReset_nxt = coreReset_r;
        brkSeen_nxt = brkSeen_r;
        ispSeen_nxt = ispSeen_r;
        fetch_nxt = fetch_r;
        // R20: hold while active
        if (anySrc) begin
            hold_nxt = 8'(HOLD_CYC);
            coreReset_nxt = 1'b1;
            if (srcBus.brkReq) begin
                brkSeen_nxt = 1'b1;
            end
            if (srcBus.poReq) begin
                brkSeen_nxt = 1'b0;
                ispSeen_nxt = forcedIsp;
            end
        end else if (hold_r != 8'h00) begin
            hold_nxt = hold_r - 8'h01;
        end else if (coreReset_r) begin
            coreReset_nxt = 1'b0;
            // R18: vector on release
            fetch_nxt = bootSel ? {bootVector, `RPMC_VEC_LOW} : `RPMC_VEC_ZERO;
            brkSeen_nxt = 1'b0;
            ispSeen_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_r <= 8'h00;
            coreReset_r <= 1'b1;
            brkSeen_r <= 1'b0;
            ispSeen_r <= 1'b0;
            fetch_r <= `RPMC_VEC_ZERO;
        end else begin
            hold_r <= hold_nxt;
            coreReset_r <= coreReset_nxt;
            brkSeen_r <= brkSeen_nxt;
            ispSeen_r <= ispSeen_nxt;
            fetch_r <= fetch_nxt;
        end
    end

    // ******************************************
    // reset source flags
    // ******************************************
    logic [NFLAGS-1:0] flags_r, flags_nxt;
    logic [NFLAGS-1:0] setVec;

    assign setVec[`RPMC_FLAG_EXT] = srcBus.extReq;
    assign setVec[`RPMC_FLAG_BO] = srcBus.boReq;
    assign setVec[`RPMC_FLAG_WDT] = srcBus.wdtReq;
    assign setVec[`RPMC_FLAG_SW] = srcBus.swReq;
    assign setVec[`RPMC_FLAG_BRK] = srcBus.brkReq;
    assign setVec[`RPMC_FLAG_PO] = 1'b0;

    always_comb begin
        flags_nxt = flags_r;
        // R16: power-on pattern
        if (srcBus.poReq) begin
            flags_nxt = `RPMC_FLAGS_POR;
        end else begin
            // R15: write 0 clears
            if (flagWrite) begin
                flags_nxt = flags_r & flagWriteData;
            end
            // R14 R17: sticky, set wins
            flags_nxt = flags_nxt | setVec;
        end
    end

    // R4: power_on_flag sticky
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_r <= `RPMC_FLAGS_POR;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // ******************************************
    // power reduction modes
    // ******************************************
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            RPMC_RUN: begin
                if (enterTotalPowerDown) begin
                    mode_nxt = RPMC_TPD;
                end else if (enterPowerDown) begin
                    mode_nxt = RPMC_PD;
                end else if (enterIdle) begin
                    mode_nxt = RPMC_IDLE;
                end
            end
            // R5: idle exit
            RPMC_IDLE: begin
                if (interruptPending) begin
                    mode_nxt = RPMC_RUN;
                end
            end
            // R6: power-down exit
            RPMC_PD, RPMC_TPD: begin
                if (wakeupInterrupt) begin
                    mode_nxt = RPMC_RUN;
                end
            end
            default: begin
                mode_nxt = RPMC_RUN;
            end
        endcase
        if (anySrc || coreReset_r) begin
            mode_nxt = RPMC_RUN;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= RPMC_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // ******************************************
    // registered outputs
    // ******************************************
    logic pinIn_r, pinIn_nxt;
    logic boIrq_r, boIrq_nxt;
    logic cpuEn_r, cpuEn_nxt;
    logic perEn_r, perEn_nxt;
    logic mainOsc_r, mainOsc_nxt;
    logic rcOsc_r, rcOsc_nxt;
    logic boDet_r, boDet_nxt;
    logic cmpEn_r, cmpEn_nxt;
    logic wdtEn_r, wdtEn_nxt;
    logic sysTmr_r, sysTmr_nxt;
    logic pdNext, tpdNext;

    assign pdNext = (mode_nxt == RPMC_PD) || (mode_nxt == RPMC_TPD);
    assign tpdNext = (mode_nxt == RPMC_TPD);

    always_comb begin
        // R10 R11: pin input value
        pinIn_nxt = resetOrInputPin | resetPinEnable | powerUpActive;
        boIrq_nxt = boIrq;
        cpuEn_nxt = (mode_nxt == RPMC_RUN) && !coreReset_nxt;
        // R5: peripherals keep running in idle, stop in power-down
        perEn_nxt = !pdNext;
        // R6: oscillator stop
        mainOsc_nxt = !pdNext;
        // R8: rc oscillator exception
        rcOsc_nxt = !pdNext || (rcIsSysClock && sysTimerEnable);
        // R7 R9: detector power
        boDet_nxt = brownoutEnable && !tpdNext;
        cmpEn_nxt = !comparatorPowerDown && !tpdNext;
        // R7: watchdog and timer stay on
        wdtEn_nxt = 1'b1;
        sysTmr_nxt = sysTimerEnable;
    end

    // watchdog is off while the block is held in reset and until the first clock edge after reset is released
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinIn_r <= 1'b1;
            boIrq_r <= 1'b0;
            cpuEn_r <= 1'b0;
            perEn_r <= 1'b1;
            mainOsc_r <= 1'b1;
            rcOsc_r <= 1'b1;
            boDet_r <= 1'b0;
            cmpEn_r <= 1'b1;
            wdtEn_r <= 1'b0;
            sysTmr_r <= 1'b0;
        end else begin
            pinIn_r <= pinIn_nxt;
            boIrq_r <= boIrq_nxt;
            cpuEn_r <= cpuEn_nxt;
            perEn_r <= perEn_nxt;
            mainOsc_r <= mainOsc_nxt;
            rcOsc_r <= rcOsc_nxt;
            boDet_r <= boDet_nxt;
            cmpEn_r <= cmpEn_nxt;
            wdtEn_r <= wdtEn_nxt;
            sysTmr_r <= sysTmr_nxt;
        end
    end

    assign coreReset = coreReset_r;
    assign resetSourceFlags = flags_r;
    assign fetchAddress = fetch_r;
    assign pinInputValue = pinIn_r;
    assign brownoutIrqReq = boIrq_r;
    assign powerMode = mode_r;
    assign cpuClockEnable = cpuEn_r;
    assign periphClockEnable = perEn_r;
    assign mainOscEnable = mainOsc_r;
    assign rcOscEnable = rcOsc_r;
    assign brownoutDetEnable = boDet_r;
    assign comparatorEnable = cmpEn_r;
    assign watchdogEnable = wdtEn_r;
    assign sysTimerRun = sysTmr_r;
endmodule
